/* File: verilog/mpwc_top.sv */
`timescale 1ns/100ps
`include "mpwc_cfg.svh"

// What this block does
// - Off: key low 0.5-1 s powers on
// - On: key low 2.5-4 s powers off
// - Reset line low 100 ms resets hardware
// - Valid on press with stable supply gives power-on reset, then boot
// - D+ pull-up when boot completes, 4 s
// - After hardware reset, reboot and report start-up
// - No wake request seen: stay awake
// - Wake request high awake, low sleep
// - Wake output high wakes host, low sleeps
// - Supplies on active, low sleep, off down
module mpwc_top
  import mpwc_pkg::*;
#(
  parameter int unsigned ON_MIN_CYC  = `MPWC_T_ON_MIN_MS * `MPWC_CLK_KHZ,
  parameter int unsigned ON_MAX_CYC  = `MPWC_T_ON_MAX_MS * `MPWC_CLK_KHZ,
  parameter int unsigned OFF_MIN_CYC = `MPWC_T_OFF_MIN_MS * `MPWC_CLK_KHZ,
  parameter int unsigned OFF_MAX_CYC = `MPWC_T_OFF_MAX_MS * `MPWC_CLK_KHZ,
  parameter int unsigned RST_CYC     = `MPWC_T_RST_MS * `MPWC_CLK_KHZ,
  parameter int unsigned PD_CYC      = `MPWC_T_PD_MS * `MPWC_CLK_KHZ,
  parameter int unsigned POR_CYC     = `MPWC_T_POR_MS * `MPWC_CLK_KHZ
) (
  input  wire logic     clk_i,
  input  wire logic     sys_rst_i,
  input  wire logic     supply_good_i,
  input  wire logic     power_key_n_i,
  input  wire logic     hw_reset_n_i,
  input  wire logic     wake_req_i,
  input  wire logic     wake_host_req_i,
  output logic          core_reset_o,
  output logic          powered_o,
  output logic          sleep_o,
  output logic          usb_dplus_line_o,
  output logic          boot_complete_report_o,
  output logic          wake_host_o,
  output mpwc_supply_t  supply_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  mpwc_state_t            state_reg;
  logic [`MPWC_CNT_W-1:0] cnt_reg;
  logic                   good1_reg;
  logic                   good2_reg;
  logic                   wake1_reg;
  logic                   wake2_reg;
  logic                   wake_seen_reg;
  logic                   key_low;
  logic                   key_rel;
  logic [`MPWC_CNT_W-1:0] key_len;
  logic                   rst_low;
  logic                   rst_hit;
  logic                   on_ok;
  logic                   off_ok;
  logic                   awake;

  // Length lies within [lo, hi)
  function automatic logic in_window(input logic [`MPWC_CNT_W-1:0] len,
                                     input int unsigned lo,
                                     input int unsigned hi);
    in_window = (len >= lo[`MPWC_CNT_W-1:0]) && (len < hi[`MPWC_CNT_W-1:0]);
  endfunction : in_window

  // Rail mode for the present power state
  function automatic mpwc_rail_t rail_mode(input mpwc_state_t st,
                                           input logic aw);
    if (st == MPWC_ST_OFF) begin
      rail_mode = `MPWC_RAIL_OFF;
    end else if (!aw) begin
      rail_mode = `MPWC_RAIL_LOW;
    end else begin
      rail_mode = `MPWC_RAIL_ON;
    end
  endfunction : rail_mode

  ////////////////////////////////////////////////////////////////////////
  // Pulse timers for power key and hardware reset pins
  mpwc_low_timer #(
    .HIT_CYC (OFF_MAX_CYC)
  ) u_key_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .line_n_i  (power_key_n_i),
    .low_o     (key_low),
    .hit_o     (),
    .rel_o     (key_rel),
    .len_o     (key_len)
  );

  mpwc_low_timer #(
    .HIT_CYC (RST_CYC)
  ) u_rst_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .line_n_i  (hw_reset_n_i),
    .low_o     (rst_low),
    .hit_o     (rst_hit),
    .rel_o     (),
    .len_o     ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for supply-good and wake request pins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      good1_reg <= 1'b0;
      good2_reg <= 1'b0;
      wake1_reg <= 1'b0;
      wake2_reg <= 1'b0;
    end else begin
      good1_reg <= supply_good_i;
      good2_reg <= good1_reg;
      wake1_reg <= wake_req_i;
      wake2_reg <= wake1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Key press qualification; other lengths change nothing
  assign on_ok  = key_rel && in_window(key_len, ON_MIN_CYC, ON_MAX_CYC);
  assign off_ok = key_rel && in_window(key_len, OFF_MIN_CYC, OFF_MAX_CYC);

  // Awake until a wake request is seen, then follow its level
  assign awake  = !wake_seen_reg || wake2_reg;

  ////////////////////////////////////////////////////////////////////////
  // Remember that the host has driven a wake request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_seen_reg <= 1'b0;
    end else if (state_reg == MPWC_ST_OFF) begin
      wake_seen_reg <= 1'b0;
    end else if (wake2_reg) begin
      wake_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= MPWC_ST_OFF;
      cnt_reg   <= '0;
    end else if (!good2_reg) begin
      state_reg <= MPWC_ST_OFF;                 // Supply lost: power down
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        MPWC_ST_OFF: begin
          if (on_ok) begin
            state_reg <= MPWC_ST_POR;
            cnt_reg   <= '0;
          end
        end
        MPWC_ST_POR: begin
          if (off_ok) begin
            state_reg <= MPWC_ST_OFF;
          end else if (rst_low) begin
            cnt_reg <= '0;                      // Hold reset while line is low
          end else if (cnt_reg >= POR_CYC[`MPWC_CNT_W-1:0] - 1'b1) begin
            state_reg <= MPWC_ST_BOOT;          // Boot on reset release
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        MPWC_ST_BOOT, MPWC_ST_RUN: begin
          if (off_ok) begin
            state_reg <= MPWC_ST_OFF;
          end else if (rst_hit) begin
            state_reg <= MPWC_ST_POR;
            cnt_reg   <= '0;
          end else if (state_reg == MPWC_ST_BOOT) begin
            if (cnt_reg >= PD_CYC[`MPWC_CNT_W-1:0] - POR_CYC[`MPWC_CNT_W-1:0] - 1'b1) begin
              state_reg <= MPWC_ST_RUN;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        default: begin
          state_reg <= MPWC_ST_OFF;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core reset, power and sleep indications
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      core_reset_o <= 1'b1;
      powered_o    <= 1'b0;
      sleep_o      <= 1'b0;
    end else begin
      core_reset_o <= (state_reg == MPWC_ST_OFF) || (state_reg == MPWC_ST_POR);
      powered_o    <= (state_reg != MPWC_ST_OFF);
      sleep_o      <= (state_reg == MPWC_ST_RUN) && !awake;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // USB D+ pull-up and start-up report on boot completion
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      usb_dplus_line_o       <= 1'b0;
      boot_complete_report_o <= 1'b0;
    end else begin
      usb_dplus_line_o       <= (state_reg == MPWC_ST_RUN);
      boot_complete_report_o <= (state_reg == MPWC_ST_RUN) && !usb_dplus_line_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake line towards the host and external supply rails
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_host_o <= 1'b0;
      supply_o    <= '{`MPWC_RAIL_OFF, `MPWC_RAIL_OFF, `MPWC_RAIL_OFF};
    end else begin
      wake_host_o <= (state_reg == MPWC_ST_RUN) && wake_host_req_i;
      supply_o.ext_supply_out_a <= rail_mode(state_reg, awake);
      supply_o.ext_supply_out_b <= rail_mode(state_reg, awake);
      supply_o.card_supply_out  <= rail_mode(state_reg, awake);
    end
  end

endmodule : mpwc_top

/* File: verilog/mpwc_cfg.svh */
`ifndef MPWC_CFG_SVH
`define MPWC_CFG_SVH

// Clock rate in kHz (50 MHz)
`define MPWC_CLK_KHZ      50000

// Power key low time that turns the module on, in ms
`define MPWC_T_ON_MIN_MS  500
`define MPWC_T_ON_MAX_MS  1000

// Power key low time that turns the module off, in ms
`define MPWC_T_OFF_MIN_MS 2500
`define MPWC_T_OFF_MAX_MS 4000

// Hardware reset low time that resets the module, in ms
`define MPWC_T_RST_MS     100

// Press accepted to USB D+ pull-up, in ms
`define MPWC_T_PD_MS      4000

// Internal power-on reset hold time, in ms
`define MPWC_T_POR_MS     10

// Width of the duration counters
`define MPWC_CNT_W        32

// Supply rail modes
`define MPWC_RAIL_OFF     2'h0
`define MPWC_RAIL_LOW     2'h1
`define MPWC_RAIL_ON      2'h2

`endif

/* File: verilog/mpwc_pkg.sv */
`include "mpwc_cfg.svh"

package mpwc_pkg;

  // Power sequencer states, one-hot
  typedef enum logic [3:0] {
    MPWC_ST_OFF  = 4'h1,
    MPWC_ST_POR  = 4'h2,
    MPWC_ST_BOOT = 4'h4,
    MPWC_ST_RUN  = 4'h8
  } mpwc_state_t;

  // Mode of one external supply rail
  typedef logic [1:0] mpwc_rail_t;

  // All external supply outputs together
  typedef struct packed {
    mpwc_rail_t ext_supply_out_a;
    mpwc_rail_t ext_supply_out_b;
    mpwc_rail_t card_supply_out;
  } mpwc_supply_t;

endpackage : mpwc_pkg

/* File: verilog/mpwc_low_timer.sv */
`timescale 1ns/100ps
`include "mpwc_cfg.svh"

module mpwc_low_timer
  import mpwc_pkg::*;
#(
  parameter int unsigned HIT_CYC = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   line_n_i,
  output logic                        low_o,
  output logic                        hit_o,
  output logic                        rel_o,
  output logic [`MPWC_CNT_W-1:0]      len_o
);

  logic                   sync1_reg;
  logic                   sync2_reg;
  logic [`MPWC_CNT_W-1:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser for the pin, resets to the idle high level
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= line_n_i;
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count low cycles, saturate, report length on release
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      low_o   <= 1'b0;
      hit_o   <= 1'b0;
      rel_o   <= 1'b0;
      len_o   <= '0;
    end else begin
      low_o <= ~sync2_reg;
      hit_o <= 1'b0;
      rel_o <= 1'b0;
      if (!sync2_reg) begin
        if (cnt_reg != '1) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
        if (cnt_reg == HIT_CYC[`MPWC_CNT_W-1:0] - 1'b1) begin
          hit_o <= 1'b1;                        // Threshold reached while low
        end
      end else if (cnt_reg != '0) begin
        rel_o   <= 1'b1;                        // Low pulse ended
        len_o   <= cnt_reg;
        cnt_reg <= '0;
      end
    end
  end

endmodule : mpwc_low_timer

/* File: dv/mpwc_host.sv */
`timescale 1ns/100ps
// Host side: drives key, reset and wake lines
module mpwc_host (
  input  wire logic clk_i,
  output logic      key_n_o,
  output logic      rst_n_o,
  output logic      wake_o
);
  ////////////////////////////////////////////////////////////
  // Lines idle released, no wake request yet
  initial begin
    key_n_o = 1'b1;
    rst_n_o = 1'b1;
    wake_o  = 1'b0;
  end
  // Key held low for len cycles
  task automatic press(input int len);
    @(posedge clk_i) #1 key_n_o = 1'b0;
    repeat (len) @(posedge clk_i);
    #1 key_n_o = 1'b1;
  endtask : press
  // Reset line held low for len cycles
  task automatic hreset(input int len);
    @(posedge clk_i) #1 rst_n_o = 1'b0;
    repeat (len) @(posedge clk_i);
    #1 rst_n_o = 1'b1;
  endtask : hreset
  // Wake request level
  task automatic wake(input logic lvl);
    @(posedge clk_i) #1 wake_o = lvl;
  endtask : wake
endmodule : mpwc_host

/* File: dv/mpwc_chk.sv */
`timescale 1ns/100ps
// Port watcher of the power sequencer
module mpwc_chk
  import mpwc_pkg::*;
#(
  parameter int unsigned ON_MIN_CYC  = 10,
  parameter int unsigned ON_MAX_CYC  = 20,
  parameter int unsigned OFF_MIN_CYC = 40,
  parameter int unsigned OFF_MAX_CYC = 80,
  parameter int unsigned RST_CYC     = 8
) (
  input wire logic         clk_i,
  input wire logic         sys_rst_i,
  input wire logic         supply_good_i,
  input wire logic         power_key_n_i,
  input wire logic         hw_reset_n_i,
  input wire logic         usb_dplus_line_o,
  input wire logic         powered_o,
  input wire logic         core_reset_o,
  input wire logic         sleep_o,
  input wire logic         boot_complete_report_o,
  input wire logic         wake_host_req_i,
  input wire logic         wake_host_o,
  input wire mpwc_supply_t supply_o
);
  logic [31:0] key_cnt_reg;
  logic [31:0] rst_cnt_reg;
  ////////////////////////////////////////////////////////////
  // Length of the current key low
  always_ff @(posedge clk_i) begin
    key_cnt_reg <= (sys_rst_i || power_key_n_i) ? 32'h0 : key_cnt_reg + 32'h1;
  end
  // Length of the current reset line low
  always_ff @(posedge clk_i) begin
    rst_cnt_reg <= (sys_rst_i || hw_reset_n_i) ? 32'h0 : rst_cnt_reg + 32'h1;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Key releases after a timed low
  sequence s_on_rel;
    $rose(power_key_n_i) && supply_good_i && !powered_o && key_cnt_reg >= ON_MIN_CYC + 2
      && key_cnt_reg + 2 < ON_MAX_CYC;
  endsequence
  sequence s_off_rel;
    $rose(power_key_n_i) && powered_o && key_cnt_reg >= OFF_MIN_CYC + 2
      && key_cnt_reg + 2 < OFF_MAX_CYC;
  endsequence
  property p_on_press;   s_on_rel |-> ##[1:10] powered_o; endproperty
  property p_off_press;  s_off_rel |-> ##[1:10] !powered_o; endproperty
  property p_short;
    $rose(power_key_n_i) && !powered_o && key_cnt_reg + 2 < ON_MIN_CYC |=> (!powered_o)[*8];
  endproperty
  property p_hwrst;
    rst_cnt_reg == RST_CYC + 6 && powered_o |-> core_reset_o && !usb_dplus_line_o;
  endproperty
  property p_dplus;      $rose(usb_dplus_line_o) |-> boot_complete_report_o; endproperty
  property p_report;
    boot_complete_report_o |-> usb_dplus_line_o ##1 !boot_complete_report_o;
  endproperty
  property p_ready;      usb_dplus_line_o |-> powered_o && !core_reset_o; endproperty
  property p_off_rails;  !powered_o |-> supply_o == 6'h00; endproperty
  property p_sleep;      sleep_o |-> supply_o == 6'h15 && powered_o; endproperty
  property p_awake;      usb_dplus_line_o && !sleep_o |-> supply_o == 6'h2a; endproperty
  property p_wake_host;
    usb_dplus_line_o && $past(usb_dplus_line_o) |-> wake_host_o == $past(wake_host_req_i);
  endproperty
  a_on_press: assert property (p_on_press)
    else $error("no power-on");
  a_off_press: assert property (p_off_press)
    else $error("no power-off");
  a_short: assert property (p_short)
    else $error("short press acted");
  a_hwrst: assert property (p_hwrst)
    else $error("reset not taken");
  a_dplus: assert property (p_dplus)
    else $error("dplus without report");
  a_report: assert property (p_report)
    else $error("bad report pulse");
  a_ready: assert property (p_ready)
    else $error("dplus during reset");
  a_off_rails: assert property (p_off_rails)
    else $error("rails on while off");
  a_sleep: assert property (p_sleep)
    else $error("rails not low in sleep");
  a_awake: assert property (p_awake)
    else $error("rails not on");
  a_wake_host: assert property (p_wake_host)
    else $error("wake output wrong");
endmodule : mpwc_chk

bind mpwc_top mpwc_chk #(.ON_MIN_CYC(ON_MIN_CYC), .ON_MAX_CYC(ON_MAX_CYC),
  .OFF_MIN_CYC(OFF_MIN_CYC), .OFF_MAX_CYC(OFF_MAX_CYC), .RST_CYC(RST_CYC)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_good_i(supply_good_i),
  .power_key_n_i(power_key_n_i), .hw_reset_n_i(hw_reset_n_i), .powered_o(powered_o),
  .usb_dplus_line_o(usb_dplus_line_o), .core_reset_o(core_reset_o), .sleep_o(sleep_o),
  .boot_complete_report_o(boot_complete_report_o), .wake_host_req_i(wake_host_req_i),
  .wake_host_o(wake_host_o), .supply_o(supply_o));

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
  import mpwc_pkg::*;
  localparam int PD      = 60;
  localparam int ON_MIN  = 10;
  localparam int ON_MAX  = 20;
  localparam int OFF_MIN = 40;
  localparam int OFF_MAX = 80;
  localparam int RST     = 8;
  localparam int POR     = 5;
  logic clk_i, sys_rst_i, wake_host_req_i, key_n, rst_n, wake, supply_good;
  logic core_reset_o, powered_o, sleep_o, usb_dplus_line_o, boot_complete_report_o, wake_host_o;
  mpwc_supply_t supply_o;
  int fail_count = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////
  mpwc_host u_host (.clk_i(clk_i), .key_n_o(key_n), .rst_n_o(rst_n), .wake_o(wake));
  mpwc_top #(.ON_MIN_CYC(ON_MIN), .ON_MAX_CYC(ON_MAX), .OFF_MIN_CYC(OFF_MIN),
    .OFF_MAX_CYC(OFF_MAX), .RST_CYC(RST), .PD_CYC(PD), .POR_CYC(POR)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_good_i(supply_good), .power_key_n_i(key_n),
    .hw_reset_n_i(rst_n), .wake_req_i(wake), .wake_host_req_i(wake_host_req_i),
    .core_reset_o(core_reset_o), .powered_o(powered_o), .sleep_o(sleep_o),
    .usb_dplus_line_o(usb_dplus_line_o), .boot_complete_report_o(boot_complete_report_o),
    .wake_host_o(wake_host_o), .supply_o(supply_o));
  ////////////////////////////////////////////////////////////
  task automatic bad(input string what);
    fail_count++;
    $display("wrong value at %0t: %s", $time, what);
  endtask : bad
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) bad(what);
  endtask : chk_bit
  task automatic chk_sup(input mpwc_supply_t got, input mpwc_supply_t exp);
    checks_done++;
    if (got !== exp) bad("supply mode");
  endtask : chk_sup
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  // Bounded wait for powered (sel 0) or D+ (sel 1) to reach lvl
  task automatic wait_lvl(input bit sel, input logic lvl, input int lim, output int n);
    n = 0;
    while (((sel ? usb_dplus_line_o : powered_o) !== lvl) && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      bad("wait ran out");
      conclude();
    end
  endtask : wait_lvl
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  // Presses too short or too long while off
  task automatic t_bad_on;
    u_host.press(5);
    cyc(12);
    chk_bit(powered_o, 1'b0, "short press");
    u_host.press(30);
    cyc(12);
    chk_bit(powered_o, 1'b0, "long press");
  endtask : t_bad_on
  // Valid press, reset hold, boot to D+ with report
  task automatic t_on;
    int n;
    u_host.press(15);
    wait_lvl(1'b0, 1'b1, 20, n);
    chk_bit(core_reset_o, 1'b1, "por");
    wait_lvl(1'b1, 1'b1, PD + 20, n);
    chk_bit(n >= PD - 10 && n <= PD + 5, 1'b1, "boot time");
    chk_bit(boot_complete_report_o, 1'b1, "report");
    chk_sup(supply_o, 6'h2a);
    cyc(1);
    chk_bit(boot_complete_report_o, 1'b0, "report pulse");
    chk_bit(sleep_o, 1'b0, "default awake");
  endtask : t_on
  // Wake request levels and host wake output
  task automatic t_wake;
    u_host.wake(1'b1);
    cyc(5);
    chk_bit(sleep_o, 1'b0, "awake");
    u_host.wake(1'b0);
    cyc(5);
    chk_bit(sleep_o, 1'b1, "sleep");
    chk_sup(supply_o, 6'h15);
    wake_host_req_i = 1'b1;
    cyc(2);
    chk_bit(wake_host_o, 1'b1, "wake host");
    wake_host_req_i = 1'b0;
    cyc(2);
    chk_bit(wake_host_o, 1'b0, "host sleep");
    u_host.wake(1'b1);
    cyc(5);
    chk_sup(supply_o, 6'h2a);
  endtask : t_wake
  // Short reset ignored, long reset reboots
  task automatic t_hwrst;
    int n;
    u_host.hreset(4);
    cyc(6);
    chk_bit(usb_dplus_line_o, 1'b1, "short reset");
    u_host.hreset(18);
    chk_bit(core_reset_o, 1'b1, "hw reset");
    wait_lvl(1'b1, 1'b1, PD + 20, n);
    chk_bit(boot_complete_report_o, 1'b1, "restart report");
  endtask : t_hwrst
  // Short press ignored while on, long press powers off
  task automatic t_off;
    int n;
    u_host.press(15);
    cyc(12);
    chk_bit(powered_o, 1'b1, "short off press");
    u_host.press(50);
    wait_lvl(1'b0, 1'b0, 20, n);
    cyc(1);
    chk_sup(supply_o, 6'h00);
    chk_bit(usb_dplus_line_o, 1'b0, "dplus off");
  endtask : t_off
  // Supply loss powers down; no power-on without a good supply
  task automatic t_supply;
    int n;
    u_host.press(15);
    wait_lvl(1'b0, 1'b1, 20, n);
    supply_good = 1'b0;
    wait_lvl(1'b0, 1'b0, 10, n);
    chk_bit(core_reset_o, 1'b1, "supply lost");
    chk_sup(supply_o, 6'h00);
    u_host.press(15);
    cyc(12);
    chk_bit(powered_o, 1'b0, "press without supply");
    supply_good = 1'b1;
    cyc(4);
  endtask : t_supply
  ////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    wake_host_req_i = 1'b0;
    supply_good = 1'b1;
    cyc(4);
    sys_rst_i = 1'b0;
    cyc(1);
    chk_bit(core_reset_o, 1'b1, "reset core");
    chk_sup(supply_o, 6'h00);
    t_bad_on();
    t_on();
    t_wake();
    t_hwrst();
    t_off();
    t_supply();
    conclude();
  end
endmodule : tb
